// >>> uart_addr_pkg.sv
// Package with register map, field layouts and types of the UART address filter.
package uart_addr_pkg;

	// Register indices; the bus byte address of each register is its index times four.
	localparam logic [7:0] IDX_UART0_OWN_ADDRESS  = 8'hA9;
	localparam logic [7:0] IDX_UART0_ADDRESS_MASK = 8'hB9;
	localparam logic [7:0] IDX_UART1_ADDRESS_MASK = 8'hBA;
	localparam logic [7:0] IDX_UART1_OWN_ADDRESS  = 8'hBB;
	localparam logic [7:0] IDX_CONTROL            = 8'hC0;
	localparam logic [7:0] IDX_IRQ_STATUS         = 8'hC1;
	localparam logic [7:0] IDX_IRQ_MASK           = 8'hC2;
	localparam logic [7:0] IDX_RX_DATA0           = 8'hC3;
	localparam logic [7:0] IDX_RX_DATA1           = 8'hC4;

	// Reset values.
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [3:0] RST_CONTROL  = 4'h0;
	localparam logic [1:0] RST_IRQ      = 2'h0;

	// Control register fields, per channel n: bit 2n = multiprocessor enable,
	// bit 2n+1 = nine-bit mode (stored and read back only; the frame's mode field selects the receiver mode).
	localparam int CTL_MP_EN_POS = 0;
	localparam int CTL_NINE_POS  = 1;
	localparam int CTL_CH_STRIDE = 2;

	// Receiver mode of one channel.
	typedef enum logic [1:0] {
		MODE_SHIFT,
		MODE_ASYNC8,
		MODE_ASYNC9
	} rx_mode_t;

	// One completed frame from a receiver.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       ninth;
		logic       stop_ok;
		rx_mode_t   mode;
	} rx_frame_t;

	// Own address and mask pair of one channel.
	typedef struct packed {
		logic [7:0] own;
		logic [7:0] mask;
	} addr_cfg_t;

endpackage

// >>> uart_address_recognition.sv
// Two-channel UART receive address filter with Wishbone registers and interrupt.
//
// Contract
// - Compare address frames in hardware; set receive flag only when addressed here.
// - Recognition is active whenever multiprocessor enable is set, except in synchronous shift mode.
// - In 8-bit async mode the stop bit acts as ninth bit; needs valid stop.
// - Given match: received bits equal own bits wherever the mask bit is one.
// - Broadcast match: ones of own OR mask must be ones in received byte.
// - Frame is recognised on Given or Broadcast match of its channel.
// - Reset clears own address and mask, so every address frame matches.
// - Each channel has its own address and mask byte pair.
// - Channel 0 own address is read/write at A9H, reset zero.
// - Channel 0 mask B9H, channel 1 mask BAH, own BBH, read/write, reset zero.
// - In 9-bit modes with enable set, frames with ninth bit zero are dropped.
// - Multiprocessor enable has no effect in synchronous shift mode.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module uart_address_recognition
	import uart_addr_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Completed frames from the two receivers.
	input  wire rx_frame_t   rx0_i,
	input  wire rx_frame_t   rx1_i,
	// Receive-complete flags and interrupt.
	output logic      [1:0]  receive_complete_flag_o,
	output logic             irq_o
);

	// The register map and flag layout serve exactly two channels.
	if (CHANNELS != 2) begin : g_chk
		$error("uart_address_recognition supports exactly two channels");
	end

	// Match test of one frame against one channel's address pair.
	function automatic logic addr_match(input logic [7:0] rx, input addr_cfg_t cfg);
		logic given;
		logic bcast;
		given = ((rx ^ cfg.own) & cfg.mask) == 8'h00;
		bcast = ((cfg.own | cfg.mask) & ~rx) == 8'h00;
		return given | bcast;
	endfunction

	// Decides whether a completed frame may raise the receive flag.
	function automatic logic frame_accept(input rx_frame_t f, input addr_cfg_t cfg,
			input logic mp_en);
		logic acc;
		acc = 1'b0;
		if (f.valid) begin
			case (f.mode)
				MODE_SHIFT: acc = 1'b1;
				MODE_ASYNC8: begin
					// Stop bit plays the ninth bit here.
					acc = !mp_en || (f.stop_ok && addr_match(f.data, cfg));
				end
				MODE_ASYNC9: begin
					acc = !mp_en || (f.ninth && addr_match(f.data, cfg));
				end
				default: acc = 1'b0;
			endcase
		end
		return acc;
	endfunction

	// Register state.
	addr_cfg_t  cfg_q [2];
	addr_cfg_t  cfg_d [2];
	logic [3:0] ctl_q;
	logic [3:0] ctl_d;
	logic [1:0] irq_status_q;
	logic [1:0] irq_status_d;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_mask_d;
	logic [7:0] rx_data_q [2];
	logic [7:0] rx_data_d [2];
	logic [31:0] dat_q;
	logic [31:0] dat_d;
	logic        ack_q;
	logic        ack_d;
	logic [1:0]  accept;
	rx_frame_t   frame [2];
	logic        wr_hit;
	logic [7:0]  idx;
	logic [7:0]  wbyte;

	assign frame[0] = rx0_i;
	assign frame[1] = rx1_i;
	assign idx      = adr_i[9:2];
	assign wbyte    = dat_i[7:0];
	assign wr_hit   = cyc_i && stb_i && we_i && !ack_q && sel_i[0];

	// Each channel judges its frame with its own pair only, on the frame-done strobe.
	for (genvar c = 0; c < 2; c++) begin : g_ch
		assign accept[c] = frame_accept(frame[c], cfg_q[c],
			ctl_q[c*CTL_CH_STRIDE+CTL_MP_EN_POS]);
	end

	// Next state of registers: a hardware set beats a software clear.
	always_comb begin
		cfg_d        = cfg_q;
		ctl_d        = ctl_q;
		irq_mask_d   = irq_mask_q;
		rx_data_d    = rx_data_q;
		irq_status_d = irq_status_q;
		if (wr_hit) begin
			case (idx)
				IDX_UART0_OWN_ADDRESS:  cfg_d[0].own  = wbyte;
				IDX_UART0_ADDRESS_MASK: cfg_d[0].mask = wbyte;
				IDX_UART1_ADDRESS_MASK: cfg_d[1].mask = wbyte;
				IDX_UART1_OWN_ADDRESS:  cfg_d[1].own  = wbyte;
				IDX_CONTROL:            ctl_d         = wbyte[3:0];
				IDX_IRQ_MASK:           irq_mask_d    = wbyte[1:0];
				IDX_IRQ_STATUS:         irq_status_d  = irq_status_q & ~wbyte[1:0];
				default:                ;
			endcase
		end
		for (int c = 0; c < 2; c++) begin
			if (accept[c]) begin
				rx_data_d[c]    = frame[c].data;
				irq_status_d[c] = 1'b1;
			end
		end
	end

	// Bus answer: one cycle after the request, dropped the cycle after.
	always_comb begin
		ack_d = cyc_i && stb_i && !ack_q;
		dat_d = 32'h0000_0000;
		if (cyc_i && stb_i && !we_i && !ack_q) begin
			case (idx)
				IDX_UART0_OWN_ADDRESS:  dat_d[7:0] = cfg_q[0].own;
				IDX_UART0_ADDRESS_MASK: dat_d[7:0] = cfg_q[0].mask;
				IDX_UART1_ADDRESS_MASK: dat_d[7:0] = cfg_q[1].mask;
				IDX_UART1_OWN_ADDRESS:  dat_d[7:0] = cfg_q[1].own;
				IDX_CONTROL:            dat_d[3:0] = ctl_q;
				IDX_IRQ_STATUS:         dat_d[1:0] = irq_status_q;
				IDX_IRQ_MASK:           dat_d[1:0] = irq_mask_q;
				IDX_RX_DATA0:           dat_d[7:0] = rx_data_q[0];
				IDX_RX_DATA1:           dat_d[7:0] = rx_data_q[1];
				default:                dat_d = 32'h0000_0000;
			endcase
		end
	end

	// Registers; reset leaves every address accepted.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < 2; c++) begin
				cfg_q[c].own  <= RST_BYTE;
				cfg_q[c].mask <= RST_BYTE;
				rx_data_q[c]  <= RST_BYTE;
			end
			ctl_q        <= RST_CONTROL;
			irq_status_q <= RST_IRQ;
			irq_mask_q   <= RST_IRQ;
		end else begin
			cfg_q        <= cfg_d;
			ctl_q        <= ctl_d;
			irq_status_q <= irq_status_d;
			irq_mask_q   <= irq_mask_d;
			rx_data_q    <= rx_data_d;
		end
	end

	// Bus answer registers; kept apart so the reply path never waits on the filter state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end else begin
			dat_q <= dat_d;
			ack_q <= ack_d;
		end
	end

	assign dat_o                   = dat_q;
	assign ack_o                   = ack_q;
	assign receive_complete_flag_o = irq_status_q;
	assign irq_o                   = |(irq_status_q & irq_mask_q);

	// Checks beside the logic.
	sequence s_addr9_frame(int c);
		frame[c].valid && frame[c].mode == MODE_ASYNC9;
	endsequence

	a_nine_zero_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		s_addr9_frame(0) ##0 (ctl_q[0] && !frame[0].ninth) |-> !accept[0])
		else $error("ninth bit zero frame accepted");
	a_stop_needed: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx0_i.valid && rx0_i.mode == MODE_ASYNC8 && ctl_q[0] && !rx0_i.stop_ok)
		|-> !accept[0])
		else $error("frame without valid stop accepted");
	a_shift_passes: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx1_i.valid && rx1_i.mode == MODE_SHIFT) |=> irq_status_q[1])
		else $error("shift mode frame filtered");
	a_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		accept[0] |=> irq_status_q[0] && rx_data_q[0] == $past(rx0_i.data))
		else $error("accepted frame did not update flag and data");
	a_given_match: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_addr9_frame(1) ##0 (rx1_i.ninth && ctl_q[2]
		&& ((rx1_i.data ^ cfg_q[1].own) & cfg_q[1].mask) == 8'h00)) |-> accept[1])
		else $error("given address not recognised");
	a_no_match_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_addr9_frame(0) ##0 (ctl_q[0]
		&& ((rx0_i.data ^ cfg_q[0].own) & cfg_q[0].mask) != 8'h00
		&& ((cfg_q[0].own | cfg_q[0].mask) & ~rx0_i.data) != 8'h00)) |-> !accept[0])
		else $error("unmatched address accepted");
	a_reset_clear: assert property (@(posedge clk_i)
		rst_i |=> cfg_q[0] == 16'h0000 && cfg_q[1] == 16'h0000)
		else $error("address pair not cleared by reset");
	a_mp_off_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx1_i.valid && !ctl_q[2] && rx1_i.mode != MODE_SHIFT) |-> accept[1])
		else $error("frame filtered with enable clear");
	a_write_own0: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_hit && idx == IDX_UART0_OWN_ADDRESS) |=> cfg_q[0].own == $past(dat_i[7:0]))
		else $error("own address write lost");
	a_write_mask1: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_hit && idx == IDX_UART1_ADDRESS_MASK) |=> cfg_q[1].mask == $past(dat_i[7:0]))
		else $error("mask write lost");

	// Bus requests on their taking edge; the write form already requires byte lane 0.
	sequence s_wr_req(logic [7:0] ix);
		wr_hit && idx == ix;
	endsequence
	sequence s_rd_req(logic [7:0] ix);
		cyc_i && stb_i && !we_i && !ack_q && idx == ix;
	endsequence

	// Channel 0 mirrors; given match is watched on channel 1 only, broadcast match on channel 0 only.
	a_bcast_match: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_addr9_frame(0) ##0 (rx0_i.ninth && ctl_q[0]
		&& ((cfg_q[0].own | cfg_q[0].mask) & ~rx0_i.data) == 8'h00)) |-> accept[0])
		else $error("broadcast address not recognised");
	a_shift_passes0: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx0_i.valid && rx0_i.mode == MODE_SHIFT) |=> irq_status_q[0])
		else $error("shift mode frame filtered on channel 0");
	a_mp_off_pass0: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx0_i.valid && !ctl_q[0] && rx0_i.mode != MODE_SHIFT) |-> accept[0])
		else $error("channel 0 frame filtered with enable clear");

	// Channel 1 mirrors; channel 1 must judge with its own pair only.
	a_nine_zero_drop1: assert property (@(posedge clk_i) disable iff (rst_i)
		s_addr9_frame(1) ##0 (ctl_q[2] && !frame[1].ninth) |-> !accept[1])
		else $error("channel 1 ninth bit zero frame accepted");
	a_stop_needed1: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx1_i.valid && rx1_i.mode == MODE_ASYNC8 && ctl_q[2] && !rx1_i.stop_ok)
		|-> !accept[1])
		else $error("channel 1 frame without valid stop accepted");
	a_no_match1: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_addr9_frame(1) ##0 (ctl_q[2]
		&& ((rx1_i.data ^ cfg_q[1].own) & cfg_q[1].mask) != 8'h00
		&& ((cfg_q[1].own | cfg_q[1].mask) & ~rx1_i.data) != 8'h00)) |-> !accept[1])
		else $error("channel 1 accepted an address outside its pair");
	a_flag_sets1: assert property (@(posedge clk_i) disable iff (rst_i)
		accept[1] |=> irq_status_q[1] && rx_data_q[1] == $past(rx1_i.data))
		else $error("channel 1 accepted frame did not update flag and data");

	// The received byte and the flag move only on a recognised frame or a clear.
	a_reject_keeps0: assert property (@(posedge clk_i) disable iff (rst_i)
		!accept[0] |=> rx_data_q[0] == $past(rx_data_q[0]))
		else $error("channel 0 byte changed without a recognised frame");
	a_reject_keeps1: assert property (@(posedge clk_i) disable iff (rst_i)
		!accept[1] |=> rx_data_q[1] == $past(rx_data_q[1]))
		else $error("channel 1 byte changed without a recognised frame");
	a_flag_source0: assert property (@(posedge clk_i) disable iff (rst_i)
		(!accept[0] && !irq_status_q[0]) |=> !irq_status_q[0])
		else $error("channel 0 flag rose without a recognised frame");
	a_flag_source1: assert property (@(posedge clk_i) disable iff (rst_i)
		(!accept[1] && !irq_status_q[1]) |=> !irq_status_q[1])
		else $error("channel 1 flag rose without a recognised frame");
	a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_wr_req(IDX_IRQ_STATUS) ##0 (wbyte[0] && !accept[0])) |=> !irq_status_q[0])
		else $error("flag not cleared by writing one");

	// Remaining write paths of the address pairs, own address reads, and reset of flags and control.
	a_write_mask0: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_req(IDX_UART0_ADDRESS_MASK) |=> cfg_q[0].mask == $past(dat_i[7:0]))
		else $error("channel 0 mask write lost");
	a_write_own1: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_req(IDX_UART1_OWN_ADDRESS) |=> cfg_q[1].own == $past(dat_i[7:0]))
		else $error("channel 1 own address write lost");
	a_read_own0: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_req(IDX_UART0_OWN_ADDRESS) |=> ack_o && dat_o[7:0] == $past(cfg_q[0].own))
		else $error("channel 0 own address read wrong");
	a_read_own1: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_req(IDX_UART1_OWN_ADDRESS) |=> ack_o && dat_o[7:0] == $past(cfg_q[1].own))
		else $error("channel 1 own address read wrong");
	a_reset_quiet: assert property (@(posedge clk_i)
		rst_i |=> irq_status_q == RST_IRQ && ctl_q == RST_CONTROL && !ack_o)
		else $error("flags or control not cleared by reset");

endmodule

// >>> uart_master_model.sv
// Behavioural master UART that hands completed frames to the two receivers.
`timescale 1ns/1ps
module uart_master_model
	import uart_addr_pkg::*;
(
	// Clock.
	input  wire logic clk_i,
	// Completed frames towards the receivers.
	output rx_frame_t rx0_o,
	output rx_frame_t rx1_o
);
	// Idle lines start inactive.
	initial begin
		rx0_o = '0;
		rx1_o = '0;
	end
	// One frame as a one-cycle valid pulse; fields invert after it so stale bytes never pass.
	task automatic send(input logic ch, input logic [7:0] d, input logic n, input logic s,
		input rx_mode_t m);
		rx_frame_t f;
		f = '{valid: 1'b1, data: d, ninth: n, stop_ok: s, mode: m};
		@(posedge clk_i);
		if (ch) rx1_o <= f; else rx0_o <= f;
		@(posedge clk_i);
		f = ~f;
		f.valid = 1'b0;
		if (ch) rx1_o <= f; else rx0_o <= f;
	endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the UART address filter.
`timescale 1ns/1ps
module testbench;
	import uart_addr_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [9:0]  adr_i = '0;
	logic [3:0]  sel_i = 4'h1;
	logic [31:0] dat_i = '0;
	logic [31:0] dat_o;
	logic [31:0] r;
	logic        ack_o;
	logic        irq_o;
	logic [1:0]  flg;
	rx_frame_t   rx0;
	rx_frame_t   rx1;
	int          fail_count = 0;
	int          num_checks = 0;
	// Clock at 200 MHz.
	always #2.5 clk_i = ~clk_i;
	uart_master_model p (.clk_i(clk_i), .rx0_o(rx0), .rx1_o(rx1));
	uart_address_recognition dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.rx0_i(rx0), .rx1_i(rx1), .receive_complete_flag_o(flg), .irq_o(irq_o));
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task chkb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	// Classic Wishbone cycle; ack and read data are taken at the rising edge, then released.
	task wb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {i, 2'b00};
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// Sends a frame, judges the flag and, for an accepted frame, the byte, then clears the sticky flag.
	task frm(input logic ch, input logic [7:0] d, input logic n, input logic s, input rx_mode_t m,
		input logic e);
		p.send(ch, d, n, s, m);
		@(negedge clk_i);
		chkb(flg[ch], e);
		if (e) begin
			wb(1'b0, ch ? IDX_RX_DATA1 : IDX_RX_DATA0, 8'h00);
			chk(r, {24'h0, d});
		end
		wb(1'b1, IDX_IRQ_STATUS, 8'h01 << ch);
	endtask
	task t_accept;
		wb(1'b1, IDX_CONTROL, 8'h05);
		frm(1'b0, 8'h37, 1'b1, 1'b1, MODE_ASYNC9, 1'b1);
		frm(1'b1, 8'hE4, 1'b1, 1'b1, MODE_ASYNC9, 1'b1);
		frm(1'b0, 8'h37, 1'b0, 1'b1, MODE_ASYNC9, 1'b0);
		$display("t_accept done");
	endtask
	task t_regs;
		logic [7:0] a [4];
		a = '{IDX_UART0_OWN_ADDRESS, IDX_UART0_ADDRESS_MASK, IDX_UART1_ADDRESS_MASK,
			IDX_UART1_OWN_ADDRESS};
		for (int k = 0; k < 4; k++) begin
			wb(1'b0, a[k], 8'h00);
			chk(r, 32'h0);
			wb(1'b1, a[k], 8'hA5 ^ 8'(k));
			wb(1'b0, a[k], 8'h00);
			chk(r, {24'h0, 8'hA5 ^ 8'(k)});
		end
		sel_i <= 4'h0;
		wb(1'b1, IDX_UART0_OWN_ADDRESS, 8'h3C);
		sel_i <= 4'h1;
		wb(1'b0, IDX_UART0_OWN_ADDRESS, 8'h00);
		chk(r, {24'h0, 8'hA5});
		wb(1'b1, 8'h10, 8'h5A);
		wb(1'b0, 8'h10, 8'h00);
		chk(r, 32'h0);
		$display("t_regs done");
	endtask
	task t_match;
		wb(1'b1, IDX_UART0_OWN_ADDRESS, 8'hC0);
		wb(1'b1, IDX_UART0_ADDRESS_MASK, 8'hFD);
		wb(1'b1, IDX_UART1_OWN_ADDRESS, 8'hE0);
		wb(1'b1, IDX_UART1_ADDRESS_MASK, 8'hFA);
		frm(1'b0, 8'hC2, 1'b1, 1'b1, MODE_ASYNC9, 1'b1);
		frm(1'b0, 8'hC1, 1'b1, 1'b1, MODE_ASYNC9, 1'b0);
		frm(1'b0, 8'hFD, 1'b1, 1'b1, MODE_ASYNC9, 1'b1);
		frm(1'b0, 8'hC0, 1'b0, 1'b0, MODE_ASYNC8, 1'b0);
		frm(1'b0, 8'hC0, 1'b0, 1'b1, MODE_ASYNC8, 1'b1);
		frm(1'b0, 8'hC1, 1'b0, 1'b1, MODE_SHIFT, 1'b1);
		frm(1'b1, 8'hE1, 1'b1, 1'b1, MODE_ASYNC9, 1'b1);
		frm(1'b1, 8'hC2, 1'b1, 1'b1, MODE_ASYNC9, 1'b0);
		frm(1'b1, 8'hE1, 1'b0, 1'b1, MODE_ASYNC9, 1'b0);
		frm(1'b1, 8'hE1, 1'b0, 1'b0, MODE_ASYNC8, 1'b0);
		frm(1'b1, 8'hE1, 1'b0, 1'b1, MODE_ASYNC8, 1'b1);
		frm(1'b1, 8'h3C, 1'b0, 1'b0, MODE_SHIFT, 1'b1);
		wb(1'b1, IDX_CONTROL, 8'h00);
		frm(1'b0, 8'hC1, 1'b0, 1'b1, MODE_ASYNC9, 1'b1);
		frm(1'b1, 8'hC2, 1'b0, 1'b0, MODE_ASYNC8, 1'b1);
		$display("t_match done");
	endtask
	task t_irq;
		wb(1'b1, IDX_IRQ_MASK, 8'h01);
		p.send(1'b0, 8'h11, 1'b1, 1'b1, MODE_ASYNC9);
		@(negedge clk_i);
		chkb(irq_o, 1'b1);
		wb(1'b1, IDX_IRQ_MASK, 8'h00);
		chkb(irq_o, 1'b0);
		wb(1'b1, IDX_IRQ_MASK, 8'h01);
		wb(1'b1, IDX_IRQ_STATUS, 8'h01);
		chkb(irq_o, 1'b0);
		chkb(flg[0], 1'b0);
		$display("t_irq done");
	endtask
	// Mid-run reset: pairs written before it read zero and accept any address after it.
	task t_reset;
		wb(1'b1, IDX_UART0_OWN_ADDRESS, 8'h12);
		wb(1'b1, IDX_UART1_ADDRESS_MASK, 8'hFF);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, IDX_UART0_OWN_ADDRESS, 8'h00);
		chk(r, 32'h0);
		wb(1'b0, IDX_UART1_ADDRESS_MASK, 8'h00);
		chk(r, 32'h0);
		wb(1'b1, IDX_CONTROL, 8'h05);
		frm(1'b0, 8'h5B, 1'b1, 1'b1, MODE_ASYNC9, 1'b1);
		frm(1'b1, 8'hA4, 1'b1, 1'b1, MODE_ASYNC9, 1'b1);
		$display("t_reset done");
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence after a 16-cycle reset.
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_accept;
		t_regs;
		t_match;
		t_irq;
		t_reset;
		end_sim;
	end
	// Watchdog well beyond the few hundred bus cycles the tests need.
	initial begin
		#40000;
		fail_count++;
		end_sim;
	end
endmodule
